// [common/opc_pkg.sv]
// Constants and types shared by the output port and clock-out logic
package opc_pkg;

  // ==========================================================================
  // Port shape
  localparam int NUM_PINS = 12;
  localparam int GROUP_W = 4;
  localparam int TIMER_PIN = 2;
  localparam int OSC_PIN = 3;

  // ==========================================================================
  // Register indices (byte address is index times four)
  localparam int AXI_AW = 10;
  localparam logic [7:0] IDX_CLKOUT_CTL = 8'h06;
  localparam logic [7:0] IDX_G0_FLOAT = 8'h30;
  localparam logic [7:0] IDX_G0_DATA = 8'h31;
  localparam logic [7:0] IDX_G1_FLOAT = 8'h32;
  localparam logic [7:0] IDX_G1_DATA = 8'h33;
  localparam logic [7:0] IDX_G2_FLOAT = 8'h34;
  localparam logic [7:0] IDX_G2_DATA = 8'h35;
  localparam logic [7:0] IDX_TIMER_CTL = 8'h36;
  localparam logic [7:0] IDX_PIN_STATE = 8'h37;

  // ==========================================================================
  // Field positions
  localparam int FREQ_LSB = 0;
  localparam int FREQ_MSB = 1;
  localparam int OSC_EN_BIT = 3;
  localparam int TIMER_EN_BIT = 0;
  localparam int FLOAT_BIT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [GROUP_W-1:0] DATA_RST = 4'hf;
  localparam logic [GROUP_W-1:0] G0_FLOAT_RST = 4'h0;
  localparam logic FLOAT_RST = 1'b0;
  localparam logic EN_RST = 1'b0;
  localparam logic [NUM_PINS-1:0] PINS_HIGH = 12'hfff;
  localparam logic [NUM_PINS-1:0] PINS_DRIVEN = 12'hfff;

  // ==========================================================================
  // Clock-out frequency select and divider taps
  typedef enum logic [1:0] {
    OPC_FREQ_DIV64 = 2'h0,
    OPC_FREQ_DIV8 = 2'h1,
    OPC_FREQ_LOW = 2'h2,
    OPC_FREQ_HIGH = 2'h3
  } opc_freq_t;
  localparam opc_freq_t FREQ_RST = OPC_FREQ_DIV64;
  localparam int DIV_BITS = 6;
  localparam int DIV8_TAP = 2;
  localparam int DIV64_TAP = 5;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [common/opc_clk_if.sv]
// Link between the port logic and the oscillator clock-out generator
`timescale 1ns/1ps
interface opc_clk_if;
  import opc_pkg::*;
  logic osc_en;
  opc_freq_t sel;
  logic osc_clk;
  modport ctl (output osc_en, output sel, input osc_clk);
  modport gen (input osc_en, input sel, output osc_clk);
endinterface

// [rtl/opc_clkgen.sv]
// Oscillator-derived clock output: divider, frequency select and gate
`timescale 1ns/1ps
module opc_clkgen
  import opc_pkg::*;
#(
  parameter int DIV_W = DIV_BITS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic low_speed_osc_clk,
  input wire logic high_speed_osc_clk,
  opc_clk_if.gen clk_if
);

  if (DIV_W <= DIV64_TAP) begin : g_chk
    $error("opc_clkgen: DIV_W too small for the divide-by-64 tap");
  end

  logic ls_prev_ff;
  logic nxt_ls_prev;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic out_ff;
  logic nxt_out;
  logic sel_lvl;

  // ==========================================================================
  // Divider counts rising edges of the low-speed clock
  always_comb begin
    nxt_ls_prev = low_speed_osc_clk;
    nxt_div = div_ff;
    if (low_speed_osc_clk && !ls_prev_ff) begin
      nxt_div = div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
    end
    case (clk_if.sel)
      OPC_FREQ_DIV64: sel_lvl = div_ff[DIV64_TAP];
      OPC_FREQ_DIV8: sel_lvl = div_ff[DIV8_TAP];
      OPC_FREQ_LOW: sel_lvl = low_speed_osc_clk;
      OPC_FREQ_HIGH: sel_lvl = high_speed_osc_clk;
      default: sel_lvl = 1'b0;
    endcase
    // Plain gate, not edge-aligned: a runt pulse is possible at switching
    nxt_out = clk_if.osc_en & sel_lvl;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ls_prev_ff <= 1'b0;
      div_ff <= '0;
      out_ff <= 1'b0;
    end else begin
      ls_prev_ff <= nxt_ls_prev;
      div_ff <= nxt_div;
      out_ff <= nxt_out;
    end
  end

  assign clk_if.osc_clk = out_ff;

  // ==========================================================================
  // Checks
  property p_high_sel;
    @(posedge aclk) disable iff (!aresetn)
    (clk_if.osc_en && clk_if.sel == OPC_FREQ_HIGH)
      |=> (out_ff == $past(high_speed_osc_clk));
  endproperty
  a_high_sel: assert property (p_high_sel)
    else $error("high-speed select not passed through");

  property p_div8_sel;
    @(posedge aclk) disable iff (!aresetn)
    (clk_if.osc_en && clk_if.sel == OPC_FREQ_DIV8)
      |=> (out_ff == $past(div_ff[DIV8_TAP]));
  endproperty
  a_div8_sel: assert property (p_div8_sel)
    else $error("divide-by-8 tap not selected");

  property p_gate_off;
    @(posedge aclk) disable iff (!aresetn)
    !clk_if.osc_en |=> !out_ff;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("clock out toggles while disabled");

endmodule

// [rtl/opc_top.sv]
// Twelve-bit output port with timer and oscillator clock outputs
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Twelve output bits in three groups of four, each from its own data bit.
// - After reset all pins are plain outputs with no special clock routed.
// - Reset sets every data bit to one and every float bit to zero.
// - Float bit one floats its pins; zero drives the data level.
// - Group zero floats per bit; groups one and two float as a whole.
// - Group zero bit two can carry the timer clock, gated by its enable.
// - Group zero bit three can carry the oscillator clock, gated by its enable.
// - With a special clock selected, data bit zero forces the pin low.
// - With a special clock selected, float bit one floats the pin.
// - Oscillator clock offers four frequencies from a two-bit select.
// - Select: 0 low/64, 1 low/8, 2 low clock, 3 high clock.
// - Switching a special clock on or off may glitch; no edge sync.
module opc_top
  import opc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_speed_osc_clk,
  input wire logic high_speed_osc_clk,
  input wire logic timer_clock_out,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe
);

  // ==========================================================================
  // Register file state
  logic [GROUP_W-1:0] g0_data_ff, nxt_g0_data;
  logic [GROUP_W-1:0] g1_data_ff, nxt_g1_data;
  logic [GROUP_W-1:0] g2_data_ff, nxt_g2_data;
  logic [GROUP_W-1:0] g0_float_ff, nxt_g0_float;
  logic group1_float_ff, nxt_group1_float;
  logic group2_float_ff, nxt_group2_float;
  logic osc_clock_out_enable_ff, nxt_osc_clock_out_enable;
  logic timer_clock_out_enable_ff, nxt_timer_clock_out_enable;
  opc_freq_t freq_sel_ff, nxt_freq_sel;

  // ==========================================================================
  // Bus state
  logic aw_held_ff, nxt_aw_held;
  logic [AXI_AW-1:0] aw_addr_ff, nxt_aw_addr;
  logic w_held_ff, nxt_w_held;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  logic aw_have, w_have, do_write;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] wr_idx, rd_idx;
  logic wr_hit, rd_hit;

  logic [NUM_PINS-1:0] pin_out_ff, nxt_pin_out;
  logic [NUM_PINS-1:0] pin_oe_ff, nxt_pin_oe;
  logic [NUM_PINS-1:0] data_all, float_all, special_lvl;

  opc_clk_if clk_if ();

  opc_clkgen u_clkgen (
    .aclk (aclk),
    .aresetn (aresetn),
    .low_speed_osc_clk (low_speed_osc_clk),
    .high_speed_osc_clk (high_speed_osc_clk),
    .clk_if (clk_if.gen)
  );

  assign clk_if.osc_en = osc_clock_out_enable_ff;
  assign clk_if.sel = freq_sel_ff;

  // ==========================================================================
  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign aw_have = aw_held_ff || (s_axi_awvalid && s_axi_awready);
  assign w_have = w_held_ff || (s_axi_wvalid && s_axi_wready);
  assign do_write = aw_have && w_have;
  assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
  assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
  assign wr_idx = wr_addr[AXI_AW-1:2];
  assign rd_idx = s_axi_araddr[AXI_AW-1:2];

  always_comb begin
    case (wr_idx)
      IDX_CLKOUT_CTL, IDX_G0_FLOAT, IDX_G0_DATA, IDX_G1_FLOAT,
      IDX_G1_DATA, IDX_G2_FLOAT, IDX_G2_DATA, IDX_TIMER_CTL,
      IDX_PIN_STATE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    case (rd_idx)
      IDX_CLKOUT_CTL, IDX_G0_FLOAT, IDX_G0_DATA, IDX_G1_FLOAT,
      IDX_G1_DATA, IDX_G2_FLOAT, IDX_G2_DATA, IDX_TIMER_CTL,
      IDX_PIN_STATE: rd_hit = 1'b1;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_held = w_held_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_held = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ==========================================================================
  // AXI4-Lite read path: answer one cycle after the address is taken
  assign s_axi_arready = !rvalid_ff;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      nxt_rdata = '0;
      case (rd_idx)
        IDX_CLKOUT_CTL: begin
          nxt_rdata[FREQ_MSB:FREQ_LSB] = freq_sel_ff;
          nxt_rdata[OSC_EN_BIT] = osc_clock_out_enable_ff;
        end
        IDX_G0_FLOAT: nxt_rdata[GROUP_W-1:0] = g0_float_ff;
        IDX_G0_DATA: nxt_rdata[GROUP_W-1:0] = g0_data_ff;
        IDX_G1_FLOAT: nxt_rdata[FLOAT_BIT] = group1_float_ff;
        IDX_G1_DATA: nxt_rdata[GROUP_W-1:0] = g1_data_ff;
        IDX_G2_FLOAT: nxt_rdata[FLOAT_BIT] = group2_float_ff;
        IDX_G2_DATA: nxt_rdata[GROUP_W-1:0] = g2_data_ff;
        IDX_TIMER_CTL: nxt_rdata[TIMER_EN_BIT] = timer_clock_out_enable_ff;
        // Live pin levels, floated pins read as zero
        IDX_PIN_STATE: nxt_rdata[NUM_PINS-1:0] = pin_out_ff & pin_oe_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  // ==========================================================================
  // Register file writes; only byte lane 0 carries fields
  always_comb begin
    nxt_g0_data = g0_data_ff;
    nxt_g1_data = g1_data_ff;
    nxt_g2_data = g2_data_ff;
    nxt_g0_float = g0_float_ff;
    nxt_group1_float = group1_float_ff;
    nxt_group2_float = group2_float_ff;
    nxt_osc_clock_out_enable = osc_clock_out_enable_ff;
    nxt_timer_clock_out_enable = timer_clock_out_enable_ff;
    nxt_freq_sel = freq_sel_ff;
    if (do_write && wr_strb[0]) begin
      case (wr_idx)
        IDX_CLKOUT_CTL: begin
          nxt_freq_sel = opc_freq_t'(wr_data[FREQ_MSB:FREQ_LSB]);
          nxt_osc_clock_out_enable = wr_data[OSC_EN_BIT];
        end
        IDX_G0_FLOAT: nxt_g0_float = wr_data[GROUP_W-1:0];
        IDX_G0_DATA: nxt_g0_data = wr_data[GROUP_W-1:0];
        IDX_G1_FLOAT: nxt_group1_float = wr_data[FLOAT_BIT];
        IDX_G1_DATA: nxt_g1_data = wr_data[GROUP_W-1:0];
        IDX_G2_FLOAT: nxt_group2_float = wr_data[FLOAT_BIT];
        IDX_G2_DATA: nxt_g2_data = wr_data[GROUP_W-1:0];
        IDX_TIMER_CTL:
          nxt_timer_clock_out_enable = wr_data[TIMER_EN_BIT];
        default: nxt_freq_sel = freq_sel_ff;
      endcase
    end
  end

  // ==========================================================================
  // Pin drive: special clocks are ANDed with data, float always wins
  assign data_all = {g2_data_ff, g1_data_ff, g0_data_ff};
  assign float_all = {{GROUP_W{group2_float_ff}}, {GROUP_W{group1_float_ff}},
                      g0_float_ff};

  always_comb begin
    special_lvl = PINS_HIGH;
    // Disabled enable leaves a constant one, so the pin is plain data
    special_lvl[TIMER_PIN] = timer_clock_out_enable_ff ?
                             timer_clock_out : 1'b1;
    special_lvl[OSC_PIN] = osc_clock_out_enable_ff ?
                           clk_if.osc_clk : 1'b1;
    for (int i = 0; i < NUM_PINS; i++) begin
      nxt_pin_out[i] = data_all[i] & special_lvl[i];
      nxt_pin_oe[i] = !float_all[i];
    end
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      g0_data_ff <= DATA_RST;
      g1_data_ff <= DATA_RST;
      g2_data_ff <= DATA_RST;
      g0_float_ff <= G0_FLOAT_RST;
      group1_float_ff <= FLOAT_RST;
      group2_float_ff <= FLOAT_RST;
      osc_clock_out_enable_ff <= EN_RST;
      timer_clock_out_enable_ff <= EN_RST;
      freq_sel_ff <= FREQ_RST;
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_held_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
      pin_out_ff <= PINS_HIGH;
      pin_oe_ff <= PINS_DRIVEN;
    end else begin
      g0_data_ff <= nxt_g0_data;
      g1_data_ff <= nxt_g1_data;
      g2_data_ff <= nxt_g2_data;
      g0_float_ff <= nxt_g0_float;
      group1_float_ff <= nxt_group1_float;
      group2_float_ff <= nxt_group2_float;
      osc_clock_out_enable_ff <= nxt_osc_clock_out_enable;
      timer_clock_out_enable_ff <= nxt_timer_clock_out_enable;
      freq_sel_ff <= nxt_freq_sel;
      aw_held_ff <= nxt_aw_held;
      aw_addr_ff <= nxt_aw_addr;
      w_held_ff <= nxt_w_held;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;

  // ==========================================================================
  // Checks
  property p_reset_pins;
    @(posedge aclk)
    !aresetn |=> (pin_out_ff == PINS_HIGH && pin_oe_ff == PINS_DRIVEN &&
                  !timer_clock_out_enable_ff && !osc_clock_out_enable_ff);
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("pins not high and driven after reset");

  property p_group1_float;
    @(posedge aclk) disable iff (!aresetn)
    group1_float_ff |=> (pin_oe_ff[2*GROUP_W-1:GROUP_W] == '0);
  endproperty
  a_group1_float: assert property (p_group1_float)
    else $error("group 1 not floated as a whole");

  property p_g0_bit_float;
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (pin_oe_ff[GROUP_W-1:0] == ~$past(g0_float_ff));
  endproperty
  a_g0_bit_float: assert property (p_g0_bit_float)
    else $error("group 0 drive does not follow its float bits");

  property p_group2_data;
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (pin_out_ff[NUM_PINS-1:2*GROUP_W] == $past(g2_data_ff));
  endproperty
  a_group2_data: assert property (p_group2_data)
    else $error("group 2 pins do not follow data");

  property p_timer_forced_low;
    @(posedge aclk) disable iff (!aresetn)
    (timer_clock_out_enable_ff && !g0_data_ff[TIMER_PIN])
      |=> !pin_out_ff[TIMER_PIN];
  endproperty
  a_timer_forced_low: assert property (p_timer_forced_low)
    else $error("data zero does not hold timer pin low");

  property p_osc_float;
    @(posedge aclk) disable iff (!aresetn)
    (osc_clock_out_enable_ff && g0_float_ff[OSC_PIN])
      |=> !pin_oe_ff[OSC_PIN];
  endproperty
  a_osc_float: assert property (p_osc_float)
    else $error("float bit does not release clock pin");

  property p_timer_pass;
    @(posedge aclk) disable iff (!aresetn)
    (timer_clock_out_enable_ff && g0_data_ff[TIMER_PIN])
      |=> (pin_out_ff[TIMER_PIN] == $past(timer_clock_out));
  endproperty
  a_timer_pass: assert property (p_timer_pass)
    else $error("timer clock not routed to its pin");

  property p_plain_osc_pin;
    @(posedge aclk) disable iff (!aresetn)
    !osc_clock_out_enable_ff
      |=> (pin_out_ff[OSC_PIN] == $past(g0_data_ff[OSC_PIN]));
  endproperty
  a_plain_osc_pin: assert property (p_plain_osc_pin)
    else $error("disabled clock pin is not a plain output");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer not given the next cycle");

endmodule

// [verif/opc_pin_model.sv]
// External load model: the level seen on each port pin
`timescale 1ns/1ps
module opc_pin_model
  import opc_pkg::*;
(
  input wire logic aclk,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_level
);
  logic [NUM_PINS-1:0] last_ff;
  // No keeper on floated pins, so a stale level must never look valid
  always_ff @(posedge aclk) begin
    last_ff <= pin_level;
  end
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ~last_ff[i];
    end
  end
endmodule

// [verif/output_port_special_clock_out_tb_top.sv]
// Self-checking bench for the output port and clock outputs
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module output_port_special_clock_out_tb_top;
  import opc_pkg::*;
  // ==========================================================================
  // Signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic low_clk, high_clk, tmr_clk;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, d;
  logic [1:0] bresp, rresp, r;
  logic [NUM_PINS-1:0] pin_out, pin_oe, pin_level, m;
  logic [7:0] ridx [8];
  logic [3:0] rrst [8];
  int error_cnt, comparisons, i, t2, t3, seed;

  always #12.5 aclk = ~aclk;

  opc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .low_speed_osc_clk(low_clk), .high_speed_osc_clk(high_clk),
    .timer_clock_out(tmr_clk), .pin_out(pin_out), .pin_oe(pin_oe));
  opc_pin_model u_load (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_level));

  // ==========================================================================
  // Tasks and expectations
  task automatic end_sim();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] dat,
                    output logic [1:0] rsp);
    logic a, w, b;
    b = 1'b0;
    awaddr <= {idx, 2'h0};
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(negedge aclk);
      a = awvalid & awready;
      w = wvalid & wready;
      b = (bvalid === 1'b1);
      rsp = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // One idle edge so a following call never re-drives bready in this step
    @(posedge aclk);
    if (!b) begin error_cnt++; end_sim(); end
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] dat,
                    output logic [1:0] rsp);
    logic a, b;
    b = 1'b0;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(negedge aclk);
      a = arvalid & arready;
      b = (rvalid === 1'b1);
      dat = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
    if (!b) begin error_cnt++; end_sim(); end
  endtask

  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask

  // Runs the source clocks while counting pin changes on both shared pins
  task automatic run_clk(output int c2, output int c3);
    logic p2, p3;
    c2 = 0;
    c3 = 0;
    p2 = pin_level[TIMER_PIN];
    p3 = pin_level[OSC_PIN];
    for (int k = 0; k < 260; k++) begin
      if (k < 256) begin
        if (k % 4 == 3) low_clk <= ~low_clk;
        if (k % 2 == 1) high_clk <= ~high_clk;
        if (k % 2 == 1) tmr_clk <= ~tmr_clk;
      end
      @(negedge aclk);
      if (pin_level[TIMER_PIN] !== p2) c2++;
      if (pin_level[OSC_PIN] !== p3) c3++;
      p2 = pin_level[TIMER_PIN];
      p3 = pin_level[OSC_PIN];
      @(posedge aclk);
    end
  endtask

  // 32 low-clock rising edges per run
  function automatic int exp_tg(input int sel);
    case (sel)
      0: return 1;
      1: return 8;
      2: return 64;
      default: return 128;
    endcase
  endfunction

  function automatic logic [11:0] exp_oe(input logic [3:0] f0,
                                         input logic f1, input logic f2);
    return {{4{~f2}}, {4{~f1}}, ~f0};
  endfunction

  // ==========================================================================
  // Main sequence
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {low_clk, high_clk, tmr_clk, awaddr, araddr, wdata} = '0;
    error_cnt = 0;
    comparisons = 0;
    seed = 32'h4cad3757;
    ridx = '{IDX_CLKOUT_CTL, IDX_G0_FLOAT, IDX_G0_DATA, IDX_G1_FLOAT,
             IDX_G1_DATA, IDX_G2_FLOAT, IDX_G2_DATA, IDX_TIMER_CTL};
    rrst = '{4'h0, 4'h0, 4'hf, 4'h0, 4'hf, 4'h0, 4'hf, 4'h0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK(pin_out, 12'hfff)
    `CHK(pin_oe, 12'hfff)
    @(posedge aclk);
    for (i = 0; i < 8; i++) begin
      rd(ridx[i], d, r);
      `CHK(d[3:0], rrst[i])
      `CHK(r, RESP_OKAY)
    end
    for (i = 0; i < 12; i++) begin
      v = $random(seed);
      if (i == 0) v = 32'h3f000;
      wr(IDX_G0_DATA, {28'h0, v[3:0]}, r);
      wr(IDX_G1_DATA, {28'h0, v[7:4]}, r);
      wr(IDX_G2_DATA, {28'h0, v[11:8]}, r);
      wr(IDX_G0_FLOAT, {28'h0, v[15:12]}, r);
      wr(IDX_G1_FLOAT, {31'h0, v[16]}, r);
      wr(IDX_G2_FLOAT, {31'h0, v[17]}, r);
      settle();
      m = exp_oe(v[15:12], v[16], v[17]);
      `CHK(pin_oe, m)
      `CHK(pin_level & m, v[11:0] & m)
      rd(IDX_PIN_STATE, d, r);
      `CHK(d[11:0], v[11:0] & m)
    end
    wr(8'h07, 32'h0, r);
    `CHK(r, RESP_SLVERR)
    rd(8'h07, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h0)
    // Shared pins need data one and float zero before clocks go out
    for (i = 0; i < 3; i++) begin
      wr(IDX_G0_FLOAT + 8'(2 * i), 32'h0, r);
      wr(IDX_G0_DATA + 8'(2 * i), 32'hf, r);
    end
    wr(IDX_TIMER_CTL, 32'h1, r);
    `CHK(r, RESP_OKAY)
    for (i = 0; i < 4; i++) begin
      wr(IDX_CLKOUT_CTL, 32'h8 | i, r);
      rd(IDX_CLKOUT_CTL, d, r);
      `CHK(d[3:0], 4'(8 | i))
      settle();
      run_clk(t2, t3);
      `CHK(t3, exp_tg(i))
      `CHK(t2, 128)
    end
    wr(IDX_G0_DATA, 32'h3, r);
    settle();
    run_clk(t2, t3);
    `CHK({t2, t3}, 64'h0)
    `CHK(pin_level[3:2], 2'h0)
    wr(IDX_G0_DATA, 32'hf, r);
    wr(IDX_G0_FLOAT, 32'hc, r);
    settle();
    run_clk(t2, t3);
    `CHK(pin_oe[3:0], 4'h3)
    wr(IDX_G0_FLOAT, 32'h0, r);
    wr(IDX_CLKOUT_CTL, 32'h3, r);
    wr(IDX_TIMER_CTL, 32'h0, r);
    settle();
    run_clk(t2, t3);
    `CHK({t2, t3}, 64'h0)
    `CHK(pin_level[3:2], 2'h3)
    end_sim();
  end
endmodule
